// *** verilog/core_memory_pause_restart_strobe.sv ***
`timescale 1ns/100ps
module core_memory_pause_restart_strobe
    import core_pause_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    // Bus side
    input  wire logic       i_bus_init,
    input  wire logic       i_msyn,
    input  wire logic [1:0] i_mode,
    output logic            o_ssyn,
    // Timing chain events
    input  wire logic       i_chain_reset,
    input  wire logic       i_rw_clear,
    input  wire logic       i_chain_end,
    // Core array side
    output logic            o_read,
    output logic            o_write_restart_b,
    output logic            o_strobe,
    output logic            o_strobe_0,
    output logic            o_strobe_1,
    output logic            o_memory_select_lockout,
    output logic            o_pause
);
    typedef enum logic [1:0] {PH_IDLE, PH_CLK1, PH_CLK2, PH_RUN} phase_t;

    typedef struct packed {
        phase_t phase;
        logic   msyn_d;
        logic   chain_reset_d;
        logic   pause;
        logic   rw;
        logic   write_restart_flag;
        logic   wr_pulse;
        logic   strobe_armed_flag;
        logic   strobe;
        logic   ssyn;
        logic   memory_select_lockout;
        logic   timing_chain_run_flag;
    } state_t;
    state_t st_reg, st_next;

    logic       clk1;
    logic       clk2;
    logic       pause_d;
    logic       delay_running;
    logic       delay_done;
    logic [1:0] mode_q;

    assign clk1 = (st_reg.phase == PH_CLK1);
    assign clk2 = (st_reg.phase == PH_CLK2);

    //==========================================================
    // Mode latch and strobe delay
    mode_latch u_mode (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_init    (i_bus_init),
        .i_load    (clk1),
        .i_mode    (i_mode),
        .o_mode    (mode_q),
        .o_pause_d (pause_d)
    );

    strobe_delay_timer u_delay (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_init    (i_bus_init),
        .i_trigger (i_chain_reset && !st_reg.chain_reset_d),
        .o_running (delay_running),
        .o_done    (delay_done)
    );

    //==========================================================
    // Control sequencing
    always_comb begin
        st_next               = st_reg;
        st_next.msyn_d        = i_msyn;
        st_next.chain_reset_d = i_chain_reset;
        st_next.wr_pulse      = 1'b0;
        st_next.strobe        = 1'b0;

        case (st_reg.phase)
            PH_IDLE: begin
                if (i_msyn && !st_reg.msyn_d && !st_reg.memory_select_lockout) begin
                    st_next.phase = PH_CLK1;
                end
            end
            PH_CLK1: begin
                st_next.rw                    = !st_reg.pause;
                st_next.timing_chain_run_flag = 1'b1;
                st_next.phase                 = PH_CLK2;
            end
            PH_CLK2: begin
                st_next.memory_select_lockout = 1'b1;
                if (mode_q[1]) begin
                    st_next.ssyn = 1'b1;
                end
                st_next.phase = PH_RUN;
            end
            PH_RUN: begin
                if (!i_msyn) begin
                    st_next.phase = PH_IDLE;
                end
            end
            default: begin
                st_next.phase = PH_IDLE;
            end
        endcase

        // Slave sync asserted by strobe in reads; pause loads on that edge
        if (st_reg.strobe && !st_reg.ssyn && !mode_q[1]) begin
            st_next.ssyn  = 1'b1;
            st_next.pause = pause_d;
        end else if (clk2 && mode_q[1]) begin
            st_next.pause = 1'b0;
        end
        if (!i_msyn && st_reg.ssyn) begin
            st_next.ssyn = 1'b0;
        end

        if (i_rw_clear) begin
            st_next.rw = 1'b0;
        end

        // Write restart pulse
        if (st_reg.rw || st_reg.pause) begin
            st_next.write_restart_flag = 1'b0;
        end else if (!st_reg.write_restart_flag && st_reg.timing_chain_run_flag) begin
            st_next.wr_pulse           = 1'b1;
            st_next.write_restart_flag = 1'b1;
        end

        // Strobe one-shot
        if (i_chain_reset && !st_reg.chain_reset_d) begin
            st_next.strobe_armed_flag = 1'b1;
        end else if (delay_done && st_reg.strobe_armed_flag && st_reg.rw) begin
            st_next.strobe            = 1'b1;
            st_next.strobe_armed_flag = 1'b0;
        end else if (!delay_running) begin
            st_next.strobe_armed_flag = 1'b0;
        end

        // Chain end: lockout release
        if (i_chain_end) begin
            if (st_reg.rw && st_next.pause) begin
                st_next.memory_select_lockout = 1'b0;
                st_next.timing_chain_run_flag = 1'b0;
            end else if (!st_reg.rw && st_reg.write_restart_flag) begin
                st_next.memory_select_lockout = 1'b0;
                st_next.timing_chain_run_flag = 1'b0;
            end else if (!st_reg.rw && st_reg.pause) begin
                st_next.memory_select_lockout = 1'b0;
                st_next.timing_chain_run_flag = 1'b0;
            end
        end

        if (i_bus_init) begin
            st_next = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    //==========================================================
    // Outputs
    assign o_read                  = st_reg.rw;
    assign o_write_restart_b       = !st_reg.wr_pulse;
    assign o_strobe                = st_reg.strobe;
    assign o_strobe_0              = st_reg.strobe;
    assign o_strobe_1              = st_reg.strobe;
    assign o_memory_select_lockout = st_reg.memory_select_lockout;
    assign o_pause                 = st_reg.pause;
    assign o_ssyn                  = st_reg.ssyn;
endmodule // core_memory_pause_restart_strobe

// *** verilog/core_pause_pkg.sv ***
//==============================================================
//==============================================================
package core_pause_pkg;
    // Mode control codes {c01, c00}
    localparam logic [1:0] MODE_READ       = 2'h0;
    localparam logic [1:0] MODE_READ_PAUSE = 2'h1;
    localparam logic [1:0] MODE_WRITE      = 2'h2;
    localparam logic [1:0] MODE_WRITE_BYTE = 2'h3;
    // Strobe delay timing
    localparam int STROBE_DELAY_NS  = 200;
    localparam int CLK_PERIOD_NS    = 40;
    localparam int STROBE_DELAY_CYC = (STROBE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_W          = 8;
    localparam logic [DELAY_W-1:0] DELAY_ZERO = 8'h00;
    localparam logic [DELAY_W-1:0] DELAY_ONE  = 8'h01;
endpackage

// *** verilog/strobe_delay_timer.sv ***
`timescale 1ns/100ps
module strobe_delay_timer
    import core_pause_pkg::*;
#(
    parameter logic [DELAY_W-1:0] DELAY_CYC = DELAY_W'(STROBE_DELAY_CYC)
) (
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    input  wire logic i_init,
    // Trigger and status
    input  wire logic i_trigger,
    output logic      o_running,
    output logic      o_done
);
    typedef struct packed {
        logic [DELAY_W-1:0] count;
        logic               done;
    } state_t;
    state_t st_reg, st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (i_trigger && st_reg.count == DELAY_ZERO) begin
            st_next.count = DELAY_CYC;
        end else if (st_reg.count != DELAY_ZERO) begin
            st_next.count = st_reg.count - DELAY_ONE;
            st_next.done  = (st_reg.count == DELAY_ONE);
        end
        if (i_init) begin
            st_next = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_running = (st_reg.count != DELAY_ZERO);
    assign o_done    = st_reg.done;
endmodule // strobe_delay_timer

// *** verilog/mode_latch.sv ***
`timescale 1ns/100ps
module mode_latch
    import core_pause_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    input  wire logic       i_init,
    // Mode lines
    input  wire logic       i_load,
    input  wire logic [1:0] i_mode,
    output logic [1:0]      o_mode,
    output logic            o_pause_d
);
    typedef struct packed {
        logic [1:0] mode;
    } state_t;
    state_t st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        if (i_load) begin
            st_next.mode = i_mode;
        end
        if (i_init) begin
            st_next = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_mode    = st_reg.mode;
    assign o_pause_d = (st_reg.mode == MODE_READ_PAUSE);
endmodule // mode_latch

// *** test/core_pause_checker_assertions.sv ***
`timescale 1ns/100ps
module core_pause_checker
    import core_pause_pkg::*;
(
    // Clock and reset
    input wire logic       i_clk_sys,
    input wire logic       i_rst_b,
    // Bus side
    input wire logic       i_bus_init,
    input wire logic       i_msyn,
    input wire logic [1:0] i_mode,
    input wire logic       o_ssyn,
    // Chain and array side
    input wire logic       i_chain_reset,
    input wire logic       i_rw_clear,
    input wire logic       o_read,
    input wire logic       o_write_restart_b,
    input wire logic       o_strobe,
    input wire logic       o_strobe_0,
    input wire logic       o_strobe_1,
    input wire logic       o_memory_select_lockout,
    input wire logic       o_pause
);
    localparam int DLY_LO = STROBE_DELAY_CYC + 2;
    localparam int DLY_HI = STROBE_DELAY_CYC + 2;
    // ====================
    // Properties
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);
    a_strobe_bytes: assert property (
        o_strobe_0 == o_strobe && o_strobe_1 == o_strobe) else $error("byte strobes differ");
    a_strobe_single: assert property (
        o_strobe |=> !o_strobe) else $error("strobe too wide");
    a_strobe_delay: assert property (
        $rose(i_chain_reset) |-> ##[DLY_LO:DLY_HI] o_strobe) else $error("strobe delay wrong");
    a_strobe_locked: assert property (
        o_strobe |-> o_memory_select_lockout) else $error("strobe while idle");
    a_restart_single: assert property (
        !o_write_restart_b |=> o_write_restart_b) else $error("restart too wide");
    a_restart_idle: assert property (
        o_read || o_pause |-> o_write_restart_b) else $error("restart during read or pause");
    a_restart_cause: assert property (
        i_rw_clear && o_read && !o_pause |-> ##[1:2] !o_write_restart_b) else $error("restart missing");
    a_pause_set: assert property (
        $rose(o_pause) |-> o_ssyn && i_mode == MODE_READ_PAUSE) else $error("pause set wrongly");
    a_ssyn_release: assert property (
        !i_msyn && o_ssyn |=> !o_ssyn) else $error("ssyn held");
    a_ssyn_with_msyn: assert property (
        $rose(o_ssyn) |-> i_msyn) else $error("ssyn raised without msyn");
    a_write_ssyn: assert property (
        $rose(i_msyn) && !o_memory_select_lockout && i_mode[1] |-> ##[2:4] o_ssyn) else $error("write ssyn late");
    a_init_idle: assert property (
        i_bus_init |=> !o_pause && !o_memory_select_lockout && !o_strobe) else $error("init not idle");
endmodule // core_pause_checker

bind core_memory_pause_restart_strobe core_pause_checker u_chk (.i_clk_sys, .i_rst_b, .i_bus_init, .i_msyn,
    .i_mode, .o_ssyn, .i_chain_reset, .i_rw_clear, .o_read, .o_write_restart_b, .o_strobe, .o_strobe_0,
    .o_strobe_1, .o_memory_select_lockout, .o_pause);

// *** test/bus_master_model.sv ***
`timescale 1ns/100ps
module bus_master_model (
    // Clock and request
    input  wire logic       i_clk_sys,
    input  wire logic       i_go,
    input  wire logic [1:0] i_mode,
    // Bus
    input  wire logic       i_ssyn,
    output logic            o_msyn,
    output logic [1:0]      o_mode,
    output logic            o_busy
);
    logic [1:0] st_reg = 2'h0;
    initial o_msyn = 1'h0;
    initial o_mode = 2'h0;
    assign o_busy = (st_reg != 2'h0);
    // ====================
    // Interlocked handshake
    always @(posedge i_clk_sys) begin
        case (st_reg)
            2'h0: if (i_go) begin
                o_mode <= i_mode;
                st_reg <= 2'h1;
            end
            2'h1: begin
                o_msyn <= 1'h1;
                st_reg <= 2'h2;
            end
            2'h2: if (i_ssyn) begin
                o_msyn <= 1'h0;
                st_reg <= 2'h3;
            end
            default: if (!i_ssyn) begin
                // Released lines no longer show the mode
                o_mode <= ~o_mode;
                st_reg <= 2'h0;
            end
        endcase
    end
endmodule // bus_master_model

// *** test/test_core_memory_pause_restart_strobe.sv ***
`timescale 1ns/100ps
module test_core_memory_pause_restart_strobe;
    import core_pause_pkg::*;
    logic       i_clk_sys = 1'h0;
    logic       i_rst_b = 1'h0;
    logic       i_bus_init = 1'h0;
    logic       i_chain_reset = 1'h0;
    logic       i_rw_clear = 1'h0;
    logic       i_chain_end = 1'h0;
    logic       go = 1'h0;
    logic [1:0] go_md = 2'h0;
    logic       msyn, ssyn, busy, o_read, wr_b, strobe, lockout, pause;
    logic [1:0] mode;
    int         err_total, n_compared, n_str, n_wr, cyc, i;
    always #20 i_clk_sys = ~i_clk_sys;
    core_memory_pause_restart_strobe u_dut (.i_clk_sys, .i_rst_b, .i_bus_init, .i_msyn(msyn), .i_mode(mode),
        .o_ssyn(ssyn), .i_chain_reset, .i_rw_clear, .i_chain_end, .o_read, .o_write_restart_b(wr_b),
        .o_strobe(strobe), .o_strobe_0(), .o_strobe_1(), .o_memory_select_lockout(lockout), .o_pause(pause));
    bus_master_model u_master (.i_clk_sys, .i_go(go), .i_mode(go_md), .i_ssyn(ssyn), .o_msyn(msyn),
        .o_mode(mode), .o_busy(busy));
    // ====================
    // Pulse counters and timeout
    always @(posedge i_clk_sys) begin
        n_str += strobe;
        n_wr += !wr_b;
        cyc++;
        if (cyc > 5000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic pulse(input int k);
        @(posedge i_clk_sys);
        if (k == 0) i_chain_reset <= 1'h1;
        else if (k == 1) i_rw_clear <= 1'h1;
        else i_chain_end <= 1'h1;
        @(posedge i_clk_sys);
        {i_chain_reset, i_rw_clear, i_chain_end} <= 3'h0;
    endtask
    // ====================
    // One bus transaction with the timing chain played alongside
    task automatic xact(input logic [1:0] m, input logic pz);
        int s0, w0, k;
        s0 = n_str;
        w0 = n_wr;
        @(posedge i_clk_sys);
        go_md <= m;
        go <= 1'h1;
        @(posedge i_clk_sys);
        go <= 1'h0;
        for (k = 0; k < 20 && lockout !== 1'h1; k++) @(posedge i_clk_sys);
        check("read", o_read, !pz);
        if (!pz) begin
            pulse(0);
            for (k = 0; k < 20 && n_str == s0; k++) @(posedge i_clk_sys);
            pulse(2);
            pulse(1);
            repeat (3) @(posedge i_clk_sys);
            check("lockout_mid", lockout, m != MODE_READ_PAUSE);
            check("restarts", 8'(n_wr - w0), m != MODE_READ_PAUSE);
            check("strobes", 8'(n_str - s0), 8'h01);
        end
        pulse(2);
        for (k = 0; k < 20 && (lockout !== 1'h0 || busy); k++) @(posedge i_clk_sys);
        check("lockout", lockout, 1'h0);
        check("pause", pause, m == MODE_READ_PAUSE);
    endtask
    initial begin
        repeat (6) @(posedge i_clk_sys);
        i_rst_b <= 1'h1;
        for (i = 0; i < 4; i++)
            if (i != 1) xact(2'(i), 1'h0);
        xact(MODE_READ_PAUSE, 1'h0);
        xact(MODE_WRITE, 1'h1);
        xact(MODE_READ_PAUSE, 1'h0);
        xact(MODE_WRITE_BYTE, 1'h1);
        xact(MODE_READ_PAUSE, 1'h0);
        @(posedge i_clk_sys);
        i_bus_init <= 1'h1;
        @(posedge i_clk_sys);
        i_bus_init <= 1'h0;
        @(posedge i_clk_sys);
        check("pause_init", pause, 1'h0);
        xact(MODE_READ, 1'h0);
        end_sim();
    end
endmodule // test_core_memory_pause_restart_strobe
